/* File: hw/wlal_pkg.sv */
// Package for the warning latch and access lock register bank.
// Assumes a single 25 MHz system clock and word-wide register ports.
`default_nettype none
package wlal_pkg;

	// Register offsets (parameter addresses)
	localparam logic [15:0] OFS_CHANNEL_LOCK   = 16'h013c;
	localparam logic [15:0] OFS_ANALOG_ONE     = 16'h0902;
	localparam logic [15:0] OFS_LATCHED_WARN   = 16'h1c18;

	// Reset values
	localparam logic [15:0] RST_CHANNEL_LOCK   = 16'h0000;
	localparam logic [15:0] RST_LATCHED_WARN   = 16'h0000;
	localparam logic [15:0] RST_ANALOG_ONE     = 16'h0000;

	// Warning bit positions
	localparam int BIT_GENERAL      = 0;
	localparam int BIT_AMP_TEMP     = 1;
	localparam int BIT_MOTOR_TEMP   = 2;
	localparam int BIT_AMP_OVLD     = 4;
	localparam int BIT_MOTOR_OVLD   = 5;
	localparam int BIT_BRAKE_OVLD   = 6;
	localparam int BIT_CAN          = 7;
	localparam int BIT_ENCODER      = 8;
	localparam int BIT_RS485        = 9;
	localparam int BIT_POWER_REMOVE = 10;
	localparam int BIT_UNDERVOLT    = 11;
	localparam int BIT_FIELDBUS2    = 12;
	localparam int BIT_POS_INVALID  = 13;

	// Bits that may carry a warning (3, 14, 15 reserved)
	localparam logic [15:0] WARN_USED_MASK  = 16'h3ff7;
	// Bits that clear themselves once the cause is gone
	localparam logic [15:0] WARN_SELF_CLEAR = 16'h2c00;

	// Lowest reportable analogue level in millivolts
	localparam logic signed [15:0] ANALOG_MIN_MV = -16'sd10000;
	// Lock word value that blocks other channels
	localparam logic [15:0] LOCK_BLOCKED = 16'h0001;

	// Access channels
	typedef enum logic [1:0]
	{
		CH_FIELDBUS,
		CH_COMMISSION,
		CH_PANEL,
		CH_FIELDBUS2
	} wlal_chan_t;

	// One register request
	typedef struct packed
	{
		logic        valid;
		logic        write;
		wlal_chan_t  chan;
		logic [15:0] addr;
		logic [15:0] wdata;
	} wlal_req_t;

	// One register answer
	typedef struct packed
	{
		logic        valid;
		logic        refused;
		logic [15:0] rdata;
	} wlal_rsp_t;

endpackage
`default_nettype wire

/* File: hw/wlal_bank.sv */
// Warning latch, channel lock and analogue level register bank.
// Requests come from the parameter handler already in the clk_sys domain;
// live warnings, the raw analogue sample, the fault-clear strobe and the halt
// level arrive from drive logic on the same clock, so none is resynchronised.
//
// Contract
// - Fault-clear empties whole latched warning word; bits still live are reloaded in the same cycle
// - Bits 10, 11, 13 clear when cause gone
// - Latched bit one means warning was activated
// - Bits 0-2, 4-6: general, temperature, overload
// - Bits 7-11: CAN, encoder, RS485, power, undervoltage
// - Bit 12 second fieldbus, 13 position invalid
// - Bits 3, 14, 15 reserved, never set
// - Lock zero enables, one blocks other channels
// - Only fieldbus sets lock; others refused while locked
// - Input signal processing never blocked by lock
// - Analogue level read-only signed millivolts, floor -10000
// - Live warning word uses latched bit meanings
`timescale 1ns/10ps
`default_nettype none

module wlal_bank
(
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// Register access
	input  wire wlal_pkg::wlal_req_t  req,
	output var  wlal_pkg::wlal_rsp_t  rsp,
	// Drive side
	input  wire logic [15:0]          live_warning_word,
	input  wire logic                 fault_clear_command,
	input  wire logic signed [15:0]   analog_input_one,
	input  wire logic                 halt_in,
	// Status out
	output var  logic [15:0]          live_warning_out,
	output var  logic                 channels_blocked,
	output var  logic                 halt_out
);

	logic [15:0]        latched_q;
	logic [15:0]        lock_q;
	logic signed [15:0] level_q;
	logic               other_chan;
	logic               refuse;
	logic               hit_lock;
	logic               hit_level;
	logic               hit_latch;
	logic [15:0]        live_used;

	assign live_used  = live_warning_word & wlal_pkg::WARN_USED_MASK;
	assign other_chan = (req.chan != wlal_pkg::CH_FIELDBUS);
	assign hit_lock   = (req.addr == wlal_pkg::OFS_CHANNEL_LOCK);
	assign hit_level  = (req.addr == wlal_pkg::OFS_ANALOG_ONE);
	assign hit_latch  = (req.addr == wlal_pkg::OFS_LATCHED_WARN);

	assign refuse = (other_chan && (lock_q == wlal_pkg::LOCK_BLOCKED))
		|| (req.write && (hit_level || hit_latch))
		|| !(hit_lock || hit_level || hit_latch);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			latched_q <= wlal_pkg::RST_LATCHED_WARN;
		else if (fault_clear_command)
			latched_q <= live_used;
		else
			latched_q <= ((latched_q & ~(wlal_pkg::WARN_SELF_CLEAR & ~live_used)) | live_used);
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			lock_q <= wlal_pkg::RST_CHANNEL_LOCK;
		else if (req.valid && req.write && hit_lock && !other_chan)
			lock_q <= req.wdata;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			level_q <= wlal_pkg::RST_ANALOG_ONE;
		else if (analog_input_one < wlal_pkg::ANALOG_MIN_MV)
			level_q <= wlal_pkg::ANALOG_MIN_MV;
		else
			level_q <= analog_input_one;
	end

	// Answer one cycle after the request
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rsp <= '0;
		else
		begin
			rsp.valid   <= req.valid;
			rsp.refused <= req.valid && refuse;
			if (req.valid && !refuse && !req.write)
			begin
				if (hit_lock)
					rsp.rdata <= lock_q;
				else if (hit_level)
					rsp.rdata <= level_q;
				else
					rsp.rdata <= latched_q;
			end
			else
				rsp.rdata <= 16'h0000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			live_warning_out <= 16'h0000;
			halt_out         <= 1'b0;
		end
		else
		begin
			live_warning_out <= live_used;
			halt_out         <= halt_in;
		end
	end

	assign channels_blocked = (lock_q == wlal_pkg::LOCK_BLOCKED);

	AST_FAULT_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		fault_clear_command && live_used == 16'h0000 |=> latched_q == 16'h0000)
		else $error("latched word not cleared");
	AST_SELF_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
		!live_used[13] && !fault_clear_command |=> !latched_q[13])
		else $error("bit 13 did not self clear");
	AST_SET: assert property (@(posedge clk_sys) disable iff (rst)
		live_used[5] |=> latched_q[5])
		else $error("latch missed warning");
	AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
		latched_q[0] && !fault_clear_command |=> latched_q[0])
		else $error("latched bit dropped");
	AST_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)
		(latched_q & ~wlal_pkg::WARN_USED_MASK) == 16'h0000)
		else $error("reserved bit set");
	AST_LOCK_REFUSE: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && other_chan && channels_blocked |=> rsp.refused)
		else $error("locked channel not refused");
	AST_LOCK_KEEP: assert property (@(posedge clk_sys) disable iff (rst)
		other_chan |=> lock_q == $past(lock_q))
		else $error("other channel changed lock");
	AST_RO_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && req.write && hit_latch |=> rsp.refused)
		else $error("read-only write accepted");
	AST_FLOOR: assert property (@(posedge clk_sys) disable iff (rst)
		##1 level_q >= wlal_pkg::ANALOG_MIN_MV)
		else $error("level below floor");
	AST_HALT: assert property (@(posedge clk_sys) disable iff (rst)
		channels_blocked |=> halt_out == $past(halt_in))
		else $error("halt blocked by lock");

	// Steps of a register access: taken on one edge, answered on the next
	sequence s_access_taken;
		req.valid;
	endsequence

	sequence s_read_taken;
		req.valid && !req.write && !refuse;
	endsequence

	sequence s_fieldbus_lock_write;
		req.valid && req.write && hit_lock && !other_chan;
	endsequence

	// A refusal must not leak register contents on the read data
	sequence s_answer_refused;
		rsp.valid && rsp.refused && (rsp.rdata == 16'h0000);
	endsequence

	AST_ANSWER_NEXT: assert property (@(posedge clk_sys) disable iff (rst)
		s_access_taken |=> rsp.valid)
		else $error("request not answered");
	AST_ANSWER_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
		!req.valid |=> !rsp.valid)
		else $error("answer without request");
	AST_REFUSE_EMPTY: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && refuse |=> s_answer_refused)
		else $error("refused answer carries data");
	AST_LEVEL_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		req.valid && req.write && hit_level |=> rsp.refused)
		else $error("level write accepted");
	AST_LOCK_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
		s_fieldbus_lock_write |=> lock_q == $past(req.wdata))
		else $error("fieldbus lock write lost");
	AST_READ_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
		s_read_taken ##0 hit_lock |=> rsp.rdata == $past(lock_q))
		else $error("lock read wrong");
	AST_READ_LATCH: assert property (@(posedge clk_sys) disable iff (rst)
		s_read_taken ##0 hit_latch |=> rsp.rdata == $past(latched_q))
		else $error("latched read wrong");
	AST_READ_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
		s_read_taken ##0 hit_level |=> rsp.rdata == $past(level_q))
		else $error("level read wrong");
	AST_CLEAR_POWER: assert property (@(posedge clk_sys) disable iff (rst)
		!live_used[wlal_pkg::BIT_POWER_REMOVE] |=> !latched_q[wlal_pkg::BIT_POWER_REMOVE])
		else $error("bit 10 did not self clear");
	AST_CLEAR_SUPPLY: assert property (@(posedge clk_sys) disable iff (rst)
		!live_used[wlal_pkg::BIT_UNDERVOLT] |=> !latched_q[wlal_pkg::BIT_UNDERVOLT])
		else $error("bit 11 did not self clear");
	AST_SET_AMP_TEMP: assert property (@(posedge clk_sys) disable iff (rst)
		live_used[wlal_pkg::BIT_AMP_TEMP] |=> latched_q[wlal_pkg::BIT_AMP_TEMP])
		else $error("temperature warning not latched");
	AST_HOLD_ENCODER: assert property (@(posedge clk_sys) disable iff (rst)
		latched_q[wlal_pkg::BIT_ENCODER] && !fault_clear_command
		|=> latched_q[wlal_pkg::BIT_ENCODER])
		else $error("encoder warning dropped");
	AST_SET_POS_INVALID: assert property (@(posedge clk_sys) disable iff (rst)
		live_used[wlal_pkg::BIT_POS_INVALID] |=> latched_q[wlal_pkg::BIT_POS_INVALID])
		else $error("position warning not latched");
	AST_LIVE_OUT: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1 |=> live_warning_out == $past(live_used))
		else $error("live word not shown");

endmodule

`default_nettype wire

/* File: verif/wlal_master.sv */
// Register master model: fieldbus, panel, commissioning, second fieldbus.
// Assumes clk_sys only and an answer registered one cycle after the take.
`timescale 1ns/10ps
`default_nettype none
module wlal_master
(
	// Clock
	input  wire logic                clk_sys,
	// Register port
	output var  wlal_pkg::wlal_req_t req,
	input  wire wlal_pkg::wlal_rsp_t rsp
);
	initial req = '0;
	// register accesses
	// Any channel may try any access; refusing it is the device's job
	task automatic xfer(input logic [1:0] ch, input logic wr, input logic [15:0] a, d,
		output wlal_pkg::wlal_rsp_t r);
		@(posedge clk_sys);
		#1 req = {1'b1, wr, wlal_pkg::wlal_chan_t'(ch), a, d};
		@(posedge clk_sys);
		// Released fields no longer show the old request
		#1 req = {1'b0, ~wr, wlal_pkg::wlal_chan_t'(~ch), ~a, ~d};
		r = rsp;
	endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the warning latch and channel lock bank.
// Assumes one 25 MHz clock; the master model issues all register traffic.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                clk_sys, rst, fault_clear_command, halt_in, channels_blocked, halt_out;
	logic [15:0]         live_warning_word, live_warning_out, want;
	logic signed [15:0]  analog_input_one;
	wlal_pkg::wlal_req_t req;
	wlal_pkg::wlal_rsp_t rsp;
	int                  seed, i, v, n_fail, tests_run, cyc;

	wlal_bank DUT (.clk_sys, .rst, .req, .rsp, .live_warning_word, .fault_clear_command,
		.analog_input_one, .halt_in, .live_warning_out, .channels_blocked, .halt_out);
	wlal_master m (.clk_sys, .req, .rsp);

	initial
	begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end

	function logic [15:0] nxt(input logic [15:0] old, lv, input logic fc);
		return (fc ? lv : (old & ~wlal_pkg::WARN_SELF_CLEAR) | lv) & wlal_pkg::WARN_USED_MASK;
	endfunction

	task chk(input logic [17:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task acc(input logic [1:0] ch, input logic wr, input logic [15:0] a, d, er, input logic ef);
		wlal_pkg::wlal_rsp_t r;
		m.xfer(ch, wr, a, d, r);
		chk({r.valid, r.refused, r.rdata}, {1'b1, ef, er});
	endtask

	task end_of_test;
		$display("Checks %0d, errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, far above the roughly 120 cycles needed
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			end_of_test;
		end
	end

	initial
	begin
		seed = 32'ha66d2549;
		rst = 1;
		live_warning_word = 0;
		fault_clear_command = 0;
		analog_input_one = 0;
		halt_in = 0;
		want = 0;
		repeat (12) @(posedge clk_sys);
		#1 rst = 0;
		acc(0, 0, 16'h013c, 0, 0, 0);
		acc(0, 0, 16'h1c18, 0, 0, 0);
		// First pass sets every used bit; fault clear every fifth pass
		for (i = 0; i < 20; i++)
		begin
			live_warning_word = (i == 0) ? 16'hffff : 16'($random(seed));
			fault_clear_command = (i % 5 == 4);
			want = nxt(want, live_warning_word, fault_clear_command);
			@(posedge clk_sys);
			#1 fault_clear_command = 0;
			chk({2'b0, live_warning_out}, {2'b0, live_warning_word & 16'h3ff7});
			acc(0, 0, 16'h1c18, 0, want, 0);
		end
		acc(0, 1, 16'h1c18, 16'hffff, 0, 1);
		acc(0, 1, 16'h0902, 16'h1234, 0, 1);
		acc(0, 0, 16'h0abc, 0, 0, 1);
		acc(0, 0, 16'h1c18, 0, want, 0);
		analog_input_one = 16'sh8000;
		acc(0, 0, 16'h0902, 0, 16'hd8f0, 0);
		v = $random(seed) % 10000;
		analog_input_one = v[15:0];
		acc(0, 0, 16'h0902, 0, v[15:0], 0);
		// Another channel writing the open lock must leave it open
		acc(1, 1, 16'h013c, 1, 0, 0);
		chk({17'b0, channels_blocked}, 18'h0);
		acc(0, 1, 16'h013c, 1, 0, 0);
		chk({17'b0, channels_blocked}, 18'h1);
		for (i = 1; i < 4; i++)
			acc(i[1:0], 0, 16'h1c18, 0, 0, 1);
		acc(2, 1, 16'h013c, 0, 0, 1);
		halt_in = 1;
		@(posedge clk_sys);
		#1 chk({17'b0, halt_out}, 18'h1);
		halt_in = 0;
		@(posedge clk_sys);
		#1 chk({17'b0, halt_out}, 18'h0);
		acc(0, 0, 16'h013c, 0, 1, 0);
		acc(0, 1, 16'h013c, 0, 0, 0);
		chk({17'b0, channels_blocked}, 18'h0);
		for (i = 1; i < 4; i++)
			acc(i[1:0], 0, 16'h013c, 0, 0, 0);
		// Reset in mid-run must drop both the lock and the stored warnings
		acc(0, 1, 16'h013c, 1, 0, 0);
		live_warning_word = 0;
		rst = 1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 0;
		chk({17'b0, channels_blocked}, 18'h0);
		acc(0, 0, 16'h1c18, 0, 0, 0);
		acc(0, 0, 16'h013c, 0, 0, 0);
		end_of_test;
	end
endmodule
`default_nettype wire
